//--- verilog/tspe_top.sv
// Trace source packet encoder: stimulus, hardware and event packets.
// Functional notes
// - Page extension packet has source bit zero and a page of 0 to 7.
// - Issuing a page extension stores the page for later stimulus writes.
// - Emitting a synchronization packet clears the page register to zero.
// - Source packets: header with size bits never 00, then 1, 2 or 4 bytes.
// - Header bit 2 is 0 for software, 1 for hardware; top bits address.
// - Size 01 is one byte, 10 two bytes, 11 four bytes of payload.
// - Each stimulus write with trace enabled yields one packet of the written value and width.
// - Halfword writes use size 10; payload goes low byte first.
// - Software header address field holds the port number within the page.
// - Port number is page times 32 plus address; extension goes first.
// - Hardware packets come from the profiling unit and are prioritized.
// - Discriminators: 0 event wrap, 1 exception, 2 PC, 8 to 23 data.
// - Extension packets never qualify hardware source packets.
// - A counter wrapping to zero raises an event counter packet.
// - Event packet has one payload byte with one flag per counter.
// - A wrap already flagged in the pending packet needs a second packet.
// - Hardware packet arriving while the buffer is full is dropped, overflow.
// - Event header: discriminator 0, bit 2 set, size 01.
// - Flags: bit 5 cycle tap down to bit 0 extra cycle; bits 7:6 zero.
// - Extension header has bit 3 set, bits 1:0 zero, bit 7 continuation.
`timescale 1ns/100ps
`include "tspe_cfg.svh"

module tspe_top (
	input  wire logic                   clock_in,
	input  wire logic                   rst_in,
	input  wire tspe_pkg::tspe_wb_req_t wb_in,
	output tspe_pkg::tspe_wb_rsp_t      wb_out,
	input  wire tspe_pkg::tspe_hw_pkt_t hw_in,
	input  wire logic [5:0]             wrap_in,
	input  wire logic                   sync_emit_in,
	input  wire logic                   byte_ready_in,
	output tspe_pkg::tspe_byte_t        byte_out,
	output logic                        overflow_out
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Byte lanes give the access width; the value is moved to bit 0.
	// Odd lane patterns are sent as a word so no data is lost.
	function automatic tspe_pkg::tspe_stim_t stim_decode(
		input logic [3:0]  sel,
		input logic [31:0] dat
	);
		tspe_pkg::tspe_stim_t r;
		r.ss = `TSPE_SS_4B;
		r.data = dat;
		unique case (sel)
			`TSPE_SEL_B0: r = '{`TSPE_SS_1B, {24'h000000, dat[7:0]}};
			`TSPE_SEL_B1: r = '{`TSPE_SS_1B, {24'h000000, dat[15:8]}};
			`TSPE_SEL_B2: r = '{`TSPE_SS_1B, {24'h000000, dat[23:16]}};
			`TSPE_SEL_B3: r = '{`TSPE_SS_1B, {24'h000000, dat[31:24]}};
			`TSPE_SEL_H0: r = '{`TSPE_SS_2B, {16'h0000, dat[15:0]}};
			`TSPE_SEL_H1: r = '{`TSPE_SS_2B, {16'h0000, dat[31:16]}};
			default: r = '{`TSPE_SS_4B, dat};
		endcase
		return r;
	endfunction : stim_decode

	// Whole packet length in bytes for a size field.
	function automatic logic [2:0] pkt_len(input logic [1:0] ss);
		logic [2:0] n;
		n = `TSPE_LEN_5;
		if (ss == `TSPE_SS_1B) begin
			n = `TSPE_LEN_2;
		end else if (ss == `TSPE_SS_2B) begin
			n = `TSPE_LEN_3;
		end
		return n;
	endfunction : pkt_len

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------

	tspe_pkg::tspe_state_t state;
	tspe_pkg::tspe_stim_t  stim;
	tspe_pkg::tspe_hw_pkt_t hw_hold;
	logic        ack;
	logic [31:0] rd_dat;
	logic        trace_en;
	logic        stim_full;
	logic [2:0]  stim_page;
	logic [4:0]  stim_addr;
	logic [2:0]  page_reg;
	logic [5:0]  evt_pend;
	logic [5:0]  evt_next;
	logic [39:0] shreg;
	logic [2:0]  left;
	logic        at_hdr;
	logic        take_hw;
	logic        take_evt;
	logic        take_ext;
	logic        take_sw;
	logic [5:0]  next_pend;
	logic [5:0]  next_next;
	logic [5:0]  evt_lost;
	logic        hw_drop;

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------

	wire bus_req = wb_in.cyc & wb_in.stb;
	wire is_stim = ~wb_in.adr[`TSPE_ADR_SEL];
	wire stim_wr = bus_req & wb_in.we & is_stim;
	wire wr_fire = bus_req & wb_in.we & ack;
	wire busy    = stim_wr & stim_full & trace_en;

	// A full stimulus slot stalls the bus instead of losing the write.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ack <= 1'b0;
		end else begin
			ack <= bus_req & ~ack & ~busy;
		end
	end

	// Read data is captured as the answer is raised.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rd_dat <= 32'h00000000;
		end else if (is_stim) begin
			rd_dat <= {31'h00000000, ~stim_full};
		end else if (wb_in.adr == `TSPE_ADR_STATUS) begin
			rd_dat <= {24'h000000, evt_pend != `TSPE_EVT_NONE,
				hw_hold.valid, stim_full, state == tspe_pkg::TSPE_SEND,
				1'b0, page_reg};
		end else if (wb_in.adr == `TSPE_ADR_CTRL) begin
			rd_dat <= {31'h00000000, trace_en};
		end else begin
			rd_dat <= 32'h00000000;
		end
	end

	assign wb_out = '{ack, rd_dat};

	// Trace enable: writes to stimulus ports are dropped while it is off.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			trace_en <= `TSPE_EN_RST;
		end else if (wr_fire & (wb_in.adr == `TSPE_ADR_CTRL)
			& wb_in.sel[0]) begin
			trace_en <= wb_in.dat[0];
		end
	end

	// ----------------------------------------------------------------
	// Stimulus slot
	// ----------------------------------------------------------------

	// One write with trace enabled becomes one packet of the written width.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			stim_full <= 1'b0;
			stim <= '{`TSPE_SS_1B, 32'h00000000};
			stim_page <= `TSPE_PAGE_RST;
			stim_addr <= 5'h00;
		end else if (wr_fire & is_stim & trace_en) begin
			stim_full <= 1'b1;
			stim <= stim_decode(wb_in.sel, wb_in.dat);
			stim_page <= wb_in.adr[`TSPE_PAGE_LSB +: 3];
			stim_addr <= wb_in.adr[`TSPE_PORT_LSB +: 5];
		end else if (take_sw) begin
			stim_full <= 1'b0;
		end
	end

	// Page register; a sync clears it, so the decoder's page zero holds.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			page_reg <= `TSPE_PAGE_RST;
		end else if (sync_emit_in) begin
			page_reg <= `TSPE_PAGE_RST;
		end else if (take_ext) begin
			page_reg <= stim_page;
		end
	end

	// ----------------------------------------------------------------
	// Hardware source slot
	// ----------------------------------------------------------------

	// A packet with no payload size would break the framing; ignore it.
	wire hw_ok = hw_in.valid & (hw_in.size != `TSPE_SS_NONE);
	assign hw_drop = hw_ok & hw_hold.valid & ~take_hw;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			hw_hold <= '0;
		end else if (hw_ok & ~hw_drop) begin
			hw_hold <= hw_in;
		end else if (take_hw) begin
			hw_hold.valid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Event counter packets
	// ----------------------------------------------------------------

	// New wraps merge into the pending flags; a flag already pending is
	// queued for a second packet. A third repeat has nowhere to go.
	always_comb begin
		next_pend = take_evt ? evt_next : evt_pend;
		next_next = take_evt ? `TSPE_EVT_NONE : evt_next;
		evt_lost  = next_next & next_pend & wrap_in;
		next_next = next_next | (next_pend & wrap_in);
		next_pend = next_pend | wrap_in;
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			evt_pend <= `TSPE_EVT_NONE;
			evt_next <= `TSPE_EVT_NONE;
		end else begin
			evt_pend <= next_pend;
			evt_next <= next_next;
		end
	end

	// Lost hardware traffic is reported for the overflow packet.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			overflow_out <= 1'b0;
		end else begin
			overflow_out <= hw_drop | (evt_lost != `TSPE_EVT_NONE);
		end
	end

	// ----------------------------------------------------------------
	// Arbiter
	// ----------------------------------------------------------------

	// Hardware first, then events, then software; the stimulus slot can
	// stall the bus, hardware sources cannot wait.
	wire idle = state == tspe_pkg::TSPE_IDLE;
	assign take_hw  = idle & hw_hold.valid;
	assign take_evt = idle & ~hw_hold.valid & (evt_pend != `TSPE_EVT_NONE);
	wire sw_turn = idle & ~hw_hold.valid & (evt_pend == `TSPE_EVT_NONE)
		& stim_full;
	assign take_ext = sw_turn & (stim_page != page_reg);
	assign take_sw  = sw_turn & (stim_page == page_reg);

	// ----------------------------------------------------------------
	// Serializer
	// ----------------------------------------------------------------

	// A packet is loaded whole and shifted out; no new load until the
	// last byte leaves, so packets never interleave.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state <= tspe_pkg::TSPE_IDLE;
			shreg <= 40'h0000000000;
			left <= `TSPE_LEN_1;
			at_hdr <= 1'b0;
		end else begin
			unique case (state)
				tspe_pkg::TSPE_IDLE: begin
					at_hdr <= 1'b1;
					if (take_hw) begin
						state <= tspe_pkg::TSPE_SEND;
						shreg <= {hw_hold.data, hw_hold.disc,
							`TSPE_SRC_HW, hw_hold.size};
						left <= pkt_len(hw_hold.size);
					end else if (take_evt) begin
						state <= tspe_pkg::TSPE_SEND;
						shreg <= {24'h000000, `TSPE_EVT_RSV, evt_pend,
							`TSPE_DISC_EVT, `TSPE_SRC_HW,
							`TSPE_SS_1B};
						left <= `TSPE_LEN_2;
					end else if (take_ext) begin
						state <= tspe_pkg::TSPE_SEND;
						shreg <= {32'h00000000, `TSPE_EXT_CONT, stim_page,
							`TSPE_EXT_MARK, `TSPE_SRC_SW,
							`TSPE_EXT_LOW};
						left <= `TSPE_LEN_1;
					end else if (take_sw) begin
						state <= tspe_pkg::TSPE_SEND;
						shreg <= {stim.data, stim_addr, `TSPE_SRC_SW,
							stim.ss};
						left <= pkt_len(stim.ss);
					end
				end
				tspe_pkg::TSPE_SEND: begin
					if (byte_ready_in) begin
						at_hdr <= 1'b0;
						shreg <= shreg >> `TSPE_BYTE_W;
						left <= left - `TSPE_LEN_1;
						if (left == `TSPE_LEN_1) begin
							state <= tspe_pkg::TSPE_IDLE;
						end
					end
				end
				default: begin
					state <= tspe_pkg::TSPE_IDLE;
				end
			endcase
		end
	end

	assign byte_out = '{state == tspe_pkg::TSPE_SEND, shreg[7:0]};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	wire hdr_out = byte_out.valid & at_hdr;
	wire is_ext  = shreg[3] & (shreg[1:0] == `TSPE_EXT_LOW);

	a_size_nonzero: assert property (@(posedge clock_in) disable iff (rst_in)
		hdr_out & ~is_ext |-> shreg[1:0] != `TSPE_SS_NONE)
		else $error("source header with zero size");

	a_ext_format: assert property (@(posedge clock_in) disable iff (rst_in)
		hdr_out & is_ext |-> shreg[2] == `TSPE_SRC_SW
		&& shreg[7] == `TSPE_EXT_CONT && left == `TSPE_LEN_1)
		else $error("bad extension header");

	a_sync_page: assert property (@(posedge clock_in) disable iff (rst_in)
		sync_emit_in |=> page_reg == `TSPE_PAGE_RST)
		else $error("page not cleared by sync");

	a_page_store: assert property (@(posedge clock_in) disable iff (rst_in)
		take_ext & ~sync_emit_in |=> page_reg == $past(stim_page)
		&& shreg[6:4] == $past(stim_page))
		else $error("page register not loaded");

	a_len_match: assert property (@(posedge clock_in) disable iff (rst_in)
		hdr_out & ~is_ext |-> left == pkt_len(shreg[1:0]))
		else $error("packet length disagrees with size");

	a_half_order: assert property (@(posedge clock_in) disable iff (rst_in)
		take_sw & (stim.ss == `TSPE_SS_2B) |=> shreg[15:8]
		== $past(stim.data[7:0]) && shreg[23:16] == $past(stim.data[15:8]))
		else $error("halfword payload order wrong");

	a_hw_drop: assert property (@(posedge clock_in) disable iff (rst_in)
		hw_ok & hw_hold.valid & ~take_hw |=> overflow_out
		&& $stable(hw_hold))
		else $error("full slot did not drop hardware packet");

	a_evt_header: assert property (@(posedge clock_in) disable iff (rst_in)
		take_evt |=> shreg[7:0] == {`TSPE_DISC_EVT, `TSPE_SRC_HW,
		`TSPE_SS_1B} && shreg[15:14] == `TSPE_EVT_RSV)
		else $error("bad event counter header");

	a_evt_second: assert property (@(posedge clock_in) disable iff (rst_in)
		~take_evt & ((evt_pend & wrap_in) != `TSPE_EVT_NONE) |=>
		(evt_next & $past(evt_pend & wrap_in)) == $past(evt_pend & wrap_in))
		else $error("repeated wrap not queued");

	a_hold_bytes: assert property (@(posedge clock_in) disable iff (rst_in)
		byte_out.valid & ~byte_ready_in |=> byte_out.valid
		&& $stable(shreg) && $stable(left))
		else $error("packet bytes not held contiguously");

	c_ext_sent: cover property (@(posedge clock_in) disable iff (rst_in)
		take_ext ##[1:4] take_sw);
	c_half_write: cover property (@(posedge clock_in) disable iff (rst_in)
		take_sw & (stim.ss == `TSPE_SS_2B));
	c_evt_double: cover property (@(posedge clock_in) disable iff (rst_in)
		take_evt & (evt_next != `TSPE_EVT_NONE));
	c_overflow: cover property (@(posedge clock_in) disable iff (rst_in)
		overflow_out);

endmodule : tspe_top

//--- verilog/tspe_cfg.svh
// Constants of the trace source packet encoder.
`ifndef TSPE_CFG_SVH
`define TSPE_CFG_SVH
`define TSPE_ADR_W      11
`define TSPE_ADR_SEL    10
`define TSPE_ADR_STATUS 11'h400
`define TSPE_ADR_CTRL   11'h404
`define TSPE_PORT_LSB   2
`define TSPE_PAGE_LSB   7
`define TSPE_SS_1B      2'h1
`define TSPE_SS_2B      2'h2
`define TSPE_SS_4B      2'h3
`define TSPE_SS_NONE    2'h0
`define TSPE_SRC_SW     1'h0
`define TSPE_SRC_HW     1'h1
`define TSPE_EXT_MARK   1'h1
`define TSPE_EXT_LOW    2'h0
`define TSPE_EXT_CONT   1'h0
`define TSPE_DISC_EVT   5'h00
`define TSPE_PAGE_RST   3'h0
`define TSPE_EVT_RSV    2'h0
`define TSPE_EVT_NONE   6'h00
`define TSPE_EN_RST     1'h0
`define TSPE_LEN_1      3'h1
`define TSPE_LEN_2      3'h2
`define TSPE_LEN_3      3'h3
`define TSPE_LEN_5      3'h5
`define TSPE_SEL_B0     4'h1
`define TSPE_SEL_B1     4'h2
`define TSPE_SEL_B2     4'h4
`define TSPE_SEL_B3     4'h8
`define TSPE_SEL_H0     4'h3
`define TSPE_SEL_H1     4'hC
`define TSPE_BYTE_W     8
`endif

//--- verilog/tspe_pkg.sv
// Types shared by the trace source packet encoder.
package tspe_pkg;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [10:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} tspe_wb_req_t;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} tspe_wb_rsp_t;
	typedef struct packed {
		logic        valid;
		logic [4:0]  disc;
		logic [1:0]  size;
		logic [31:0] data;
	} tspe_hw_pkt_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} tspe_byte_t;
	typedef struct packed {
		logic [1:0]  ss;
		logic [31:0] data;
	} tspe_stim_t;
	typedef enum logic [1:0] {
		TSPE_IDLE = 2'h1,
		TSPE_SEND = 2'h2
	} tspe_state_t;
endpackage : tspe_pkg

//--- testbench/tspe_debugger_model.sv
// Debugger model that decodes the trace byte stream into whole packets.
`timescale 1ns/100ps

module tspe_debugger_model (
	input  wire logic                 clock_in,
	input  wire logic                 rst_in,
	input  wire tspe_pkg::tspe_byte_t byte_in,
	input  wire logic                 stall_in,
	input  wire logic                 sync_in,
	output logic                      ready_out,
	output logic                      pkt_valid_out,
	output logic [7:0]                pkt_hdr_out,
	output logic [31:0]               pkt_dat_out,
	output logic [2:0]                pkt_len_out,
	output logic [7:0]                pkt_port_out
);
	logic [2:0]  page;
	logic [2:0]  need;
	logic [2:0]  got;
	logic [7:0]  hdr;
	logic [31:0] dat;
	logic [31:0] next_dat;
	logic        take;

	// The debugger stalls only when the bench asks it to.
	assign ready_out = !stall_in;
	assign take = byte_in.valid && ready_out;

	// Page of the last extension, back to zero after every sync.
	always_ff @(posedge clock_in) begin
		if (rst_in || sync_in) begin
			page <= 3'h0;
		end else if (take && need == 3'h0 && byte_in.data[3:0] == 4'h8) begin
			page <= byte_in.data[6:4];
		end
	end

	// Payload arrives least significant byte first.
	always_comb begin
		next_dat = dat;
		next_dat[{got[1:0], 3'h0} +: 8] = byte_in.data;
	end

	// Header first; a header with size zero is an extension, no payload.
	always_ff @(posedge clock_in) begin
		pkt_valid_out <= 1'b0;
		if (rst_in) begin
			need <= 3'h0;
			got  <= 3'h0;
			dat  <= 32'h0;
		end else if (take && need == 3'h0) begin
			hdr <= byte_in.data;
			dat <= 32'h0;
			got <= 3'h0;
			need <= (byte_in.data[1:0] == 2'h3) ? 3'h4 : {1'b0, byte_in.data[1:0]};
			if (byte_in.data[1:0] == 2'h0) begin
				pkt_valid_out <= 1'b1;
				pkt_hdr_out   <= byte_in.data;
				pkt_dat_out   <= 32'h0;
				pkt_len_out   <= 3'h0;
				pkt_port_out  <= 8'h0;
			end
		end else if (take) begin
			dat <= next_dat;
			got <= got + 3'h1;
			if (got + 3'h1 == need) begin
				need          <= 3'h0;
				pkt_valid_out <= 1'b1;
				pkt_hdr_out   <= hdr;
				pkt_dat_out   <= next_dat;
				pkt_len_out   <= need;
				pkt_port_out  <= hdr[2] ? 8'h0 : {page, hdr[7:3]};
			end
		end
	end
endmodule : tspe_debugger_model

//--- testbench/tspe_top_tb.sv
// Self-checking bench for the trace source packet encoder.
`timescale 1ns/100ps

module tspe_top_tb;
	typedef struct packed {
		logic [7:0]  hdr;
		logic [31:0] dat;
		logic [2:0]  len;
		logic [7:0]  port;
	} tspe_exp_t;

	logic                   clock_in;
	logic                   rst_in;
	tspe_pkg::tspe_wb_req_t wb_in;
	tspe_pkg::tspe_wb_rsp_t wb_out;
	tspe_pkg::tspe_hw_pkt_t hw_in;
	logic [5:0]             wrap_in;
	logic                   sync_emit_in;
	logic                   byte_ready_in;
	tspe_pkg::tspe_byte_t   byte_out;
	logic                   overflow_out;
	logic                   stall;
	logic                   pkt_valid;
	tspe_exp_t              got_pkt;
	tspe_exp_t              exp_q[$];
	logic [2:0]             exp_page;
	logic [31:0]            rd;
	int                     mismatches;
	int                     checks_done;
	int                     ovf_count;
	int                     ovf_base;

	tspe_top tspe_top_i (.clock_in(clock_in), .rst_in(rst_in), .wb_in(wb_in),
		.wb_out(wb_out), .hw_in(hw_in), .wrap_in(wrap_in),
		.sync_emit_in(sync_emit_in), .byte_ready_in(byte_ready_in),
		.byte_out(byte_out), .overflow_out(overflow_out));

	tspe_debugger_model tspe_debugger_model_i (.clock_in(clock_in),
		.rst_in(rst_in), .byte_in(byte_out), .stall_in(stall),
		.sync_in(sync_emit_in), .ready_out(byte_ready_in),
		.pkt_valid_out(pkt_valid), .pkt_hdr_out(got_pkt.hdr),
		.pkt_dat_out(got_pkt.dat), .pkt_len_out(got_pkt.len),
		.pkt_port_out(got_pkt.port));

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	task automatic wrap_up;
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic check_val(input logic [50:0] got, input logic [50:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_pkt(input tspe_exp_t got, input tspe_exp_t exp);
		check_val(got, exp);
	endtask : check_pkt

	function automatic logic [31:0] cut(input logic [1:0] ss,
		input logic [31:0] d);
		return (ss == 2'h1) ? {24'h0, d[7:0]} :
			(ss == 2'h2) ? {16'h0, d[15:0]} : d;
	endfunction : cut

	// Classic cycle: hold until ack is seen, release at that edge.
	task automatic wb_cycle(input logic we, input logic [10:0] adr,
		input logic [3:0] sel, input logic [31:0] dat,
		output logic [31:0] rdat);
		int n;
		@(posedge clock_in);
		wb_in <= '{1'b1, 1'b1, we, adr, sel, dat};
		for (n = 0; n < 200; n++) begin
			@(posedge clock_in);
			if (wb_out.ack === 1'b1) break;
		end
		if (n == 200) begin
			mismatches++;
			wrap_up();
		end
		rdat = wb_out.dat;
		wb_in <= '0;
	endtask : wb_cycle

	// A stimulus write; an extension goes first when the page changes.
	task automatic stim_write(input logic [7:0] port, input logic [1:0] ss,
		input logic [31:0] dat);
		logic [1:0] ln;
		logic [3:0] sel;
		ln = 2'($urandom);
		if (ss != 2'h1) begin
			ln = (ss == 2'h2) ? {ln[1], 1'b0} : 2'h0;
		end
		sel = (ss == 2'h1) ? 4'h1 << ln : (ss == 2'h2) ? 4'h3 << ln : 4'hF;
		if (port[7:5] != exp_page) begin
			exp_page = port[7:5];
			exp_q.push_back('{{1'b0, exp_page, 4'h8}, 32'h0, 3'h0, 8'h0});
		end
		exp_q.push_back('{{port[4:0], 1'b0, ss}, cut(ss, dat >> {ln, 3'h0}),
			(ss == 2'h3) ? 3'h4 : {1'b0, ss}, port});
		wb_cycle(1'b1, {1'b0, port, 2'h0}, sel, dat, rd);
	endtask : stim_write

	task automatic hw_send(input logic [4:0] disc, input logic [1:0] ss,
		input logic [31:0] dat, input logic expect_it);
		if (expect_it) begin
			exp_q.push_back('{{disc, 1'b1, ss}, cut(ss, dat),
				(ss == 2'h3) ? 3'h4 : {1'b0, ss}, 8'h0});
		end
		@(posedge clock_in);
		hw_in <= '{1'b1, disc, ss, dat};
		@(posedge clock_in);
		hw_in.valid <= 1'b0;
	endtask : hw_send

	task automatic wrap_pulse(input logic [5:0] flags);
		@(posedge clock_in);
		wrap_in <= flags;
		@(posedge clock_in);
		wrap_in <= 6'h00;
	endtask : wrap_pulse

	function automatic tspe_exp_t evt(input logic [5:0] flags);
		return '{8'h05, {26'h0, flags}, 3'h1, 8'h0};
	endfunction : evt

	task automatic drain;
		int n;
		for (n = 0; n < 400 && exp_q.size() != 0; n++) begin
			@(posedge clock_in);
		end
		if (n == 400) begin
			mismatches++;
			wrap_up();
		end
		repeat (4) @(posedge clock_in);
	endtask : drain

	// -----------------------------------------------------------------
	// Clock, scoreboard and overflow count
	// -----------------------------------------------------------------
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	// Each decoded packet takes the oldest note off the queue.
	always @(posedge clock_in) begin
		if (pkt_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check_val(got_pkt, 51'h0);
			end else begin
				check_pkt(got_pkt, exp_q.pop_front());
			end
		end
		if (overflow_out === 1'b1) begin
			ovf_count++;
		end
	end

	// Main sequence: registers, stimulus, pages, hardware and events.
	initial begin
		int i;
		logic [7:0] ports[8];
		ports = '{8'h05, 8'h25, 8'h26, 8'h03, 8'hFF, 8'h00, 8'h1F, 8'h40};
		rst_in = 1'b1;
		wb_in = '0;
		hw_in = '0;
		wrap_in = 6'h00;
		sync_emit_in = 1'b0;
		stall = 1'b0;
		exp_page = 3'h0;
		mismatches = 0;
		checks_done = 0;
		ovf_count = 0;
		void'($urandom(32'h3FB3DD4E));
		repeat (3) @(posedge clock_in);
		rst_in <= 1'b0;
		wb_cycle(1'b1, 11'h008, 4'hF, 32'h1234_5678, rd);
		wb_cycle(1'b0, 11'h404, 4'hF, 32'h0, rd);
		check_val(rd[0], 1'b0);
		wb_cycle(1'b1, 11'h404, 4'hF, 32'h1, rd);
		wb_cycle(1'b0, 11'h404, 4'hF, 32'h0, rd);
		check_val(rd[0], 1'b1);
		wb_cycle(1'b0, 11'h408, 4'hF, 32'h0, rd);
		check_val(rd, 32'h0);
		stim_write(8'h05, 2'h2, 32'h03A1_03A1);
		for (i = 0; i < 8; i++) begin
			stim_write(ports[i], 2'(1 + i % 3), $urandom);
		end
		drain();
		wb_cycle(1'b0, 11'h400, 4'hF, 32'h0, rd);
		check_val(rd[2:0], 3'h2);
		@(posedge clock_in);
		sync_emit_in <= 1'b1;
		@(posedge clock_in);
		sync_emit_in <= 1'b0;
		exp_page = 3'h0;
		wb_cycle(1'b0, 11'h400, 4'hF, 32'h0, rd);
		check_val(rd[2:0], 3'h0);
		stim_write(8'h42, 2'h3, $urandom);
		stim_write(8'h01, 2'h1, $urandom);
		drain();
		for (i = 0; i < 24; i++) begin
			if (i < 3 || i > 7) begin
				hw_send(5'(i), 2'(1 + i % 3), $urandom, 1'b1);
				drain();
			end
		end
		hw_send(5'h01, 2'h0, $urandom, 1'b0);
		drain();
		for (i = 0; i < 6; i++) begin
			exp_q.push_back(evt(6'(1 << i)));
			wrap_pulse(6'(1 << i));
			drain();
		end
		stall <= 1'b1;
		hw_send(5'h01, 2'h2, $urandom, 1'b1);
		exp_q.push_back(evt(6'h09));
		exp_q.push_back(evt(6'h01));
		wrap_pulse(6'h01);
		wrap_pulse(6'h08);
		wrap_pulse(6'h01);
		stall <= 1'b0;
		drain();
		ovf_base = ovf_count;
		stall <= 1'b1;
		hw_send(5'h02, 2'h3, $urandom, 1'b1);
		repeat (3) @(posedge clock_in);
		hw_send(5'h08, 2'h1, $urandom, 1'b1);
		hw_send(5'h09, 2'h1, $urandom, 1'b0);
		repeat (5) @(posedge clock_in);
		stall <= 1'b0;
		drain();
		check_val(ovf_count - ovf_base, 51'h1);
		wb_cycle(1'b0, 11'h000, 4'hF, 32'h0, rd);
		check_val(rd[0], 1'b1);
		wrap_up();
	end
endmodule : tspe_top_tb
